// file: core/shbp_pkg.sv
// Purpose: Shared constants for the slave host buffer port.
// Assumes: One clock; host strobes arrive synchronous to it.
// Notes:   Status bit layout, opcodes, port-2 pin roles, cycle length.
package shbp_pkg;

  // ----------------------------------------------------------------
  // Internal instruction encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_LOAD_STATUS = 8'h90;
  localparam logic [7:0] OP_EN_FLAGS = 8'hf5;
  localparam logic [7:0] OP_EN_DMA = 8'he5;

  // ----------------------------------------------------------------
  // Status byte fields
  // ----------------------------------------------------------------
  localparam int STAT_OUT_FULL = 0;
  localparam int STAT_IN_FULL = 1;
  localparam int STAT_CMD_DATA = 3;
  localparam int USER_LO = 4;
  localparam int USER_HI = 7;
  localparam logic [3:0] USER_RESET = 4'h0;
  localparam logic [7:0] BUF_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Port-2 pin roles and reset level (quasi-bidirectional pins idle high)
  // ----------------------------------------------------------------
  localparam int P2_OUT_FULL = 4;
  localparam int P2_IN_FULL = 5;
  localparam int P2_DMA_REQ = 6;
  localparam int P2_DMA_ACK = 7;
  localparam logic [7:0] P2_RESET = 8'hff;

  // ----------------------------------------------------------------
  // Instruction cycle length in clocks
  // ----------------------------------------------------------------
  localparam int CYCLE_CLKS = 15;
  localparam logic [3:0] CYCLE_LAST = 4'(CYCLE_CLKS - 1);

  // Host access sequencer
  typedef enum logic [1:0] {HOST_IDLE, HOST_READ, HOST_WRITE} shbp_host_t;

endpackage : shbp_pkg

// file: core/shbp_port.sv
// Purpose: Host-facing data bus buffers, status byte and flag pins.
// Assumes: Host strobes are synchronous; the internal CPU issues ops.
// Notes:   Strobes act on their trailing edge; status read locks updates.
`timescale 1ns/1ps

module shbp_port (
  input wire logic clock,
  input wire logic rst,
  input wire logic clkEn,
  // Host side
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic cmdDataSelect,
  input wire logic [7:0] busIn,
  output logic [7:0] busOut,
  output logic busOe,
  // Internal CPU side
  input wire logic opValid,
  input wire logic [7:0] opCode,
  input wire logic [7:0] accIn,
  input wire logic cpuOutWr,
  input wire logic [7:0] cpuOutData,
  input wire logic cpuInRd,
  output logic [7:0] inData,
  output logic [7:0] statusByte,
  output logic cycleStrobe,
  // Port 2 and expander
  input wire logic p2Wr,
  input wire logic [7:0] p2WrData,
  input wire logic dmaAckN,
  input wire logic expActive,
  input wire logic [3:0] expNibble,
  input wire logic expStrobe,
  output logic [7:0] p2Out,
  output logic expanderStrobePin
);
  import shbp_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  shbp_host_t state_q, state_d;
  logic [7:0] inBuf_q, outBuf_q, rdData_q, wrData_q, p2Latch_q;
  logic [3:0] userBits_q, pendUserBits_q, cyc_q;
  logic outFull_q, inFull_q, cmdFlag_q, wrA0_q, rdStatus_q, viaDma_q;
  logic pendObf_q, pendIbfClr_q, pendUser_q;
  logic flagsEn_q, dmaEn_q, dmaReq_q, sync_q, expStb_q;
  logic [7:0] p2Out_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // All operands come in as arguments so each continuous assign re-evaluates on every change
  function automatic logic isOp(input logic take, input logic [7:0] code, input logic [7:0] want);
    return take && (code == want);
  endfunction : isOp

  // DMA acknowledge stands in for chip select on the data buffers
  wire dmaSel = dmaEn_q && !dmaAckN;
  wire hostSel = !csN || dmaSel;
  wire rdAct = hostSel && !rdN;
  wire wrAct = hostSel && !wrN && rdN;
  wire a0Eff = cmdDataSelect && !dmaSel;
  wire opTake = clkEn && opValid;
  wire opLoad = isOp(opTake, opCode, OP_LOAD_STATUS);
  wire opFlags = isOp(opTake, opCode, OP_EN_FLAGS);
  wire opDma = isOp(opTake, opCode, OP_EN_DMA);

  // Host sequencer: events fire when the strobe is released
  wire rdEnd = (state_q == HOST_READ) && !rdAct;
  wire wrEnd = (state_q == HOST_WRITE) && !wrAct;

  // Lock covers the sampling cycle and the whole status read
  wire statusLock = ((state_q == HOST_READ) && rdStatus_q) ||
                    ((state_q == HOST_IDLE) && rdAct && a0Eff);

  // Hardware flag updates; the set side wins a same-cycle clear
  wire obfSet = !statusLock && (cpuOutWr || pendObf_q);
  wire obfClr = rdEnd && !rdStatus_q;
  wire ibfSet = wrEnd;
  wire ibfClr = !statusLock && (cpuInRd || pendIbfClr_q);
  wire userApply = !statusLock && (opLoad || pendUser_q);
  wire [3:0] userSrc = opLoad ? accIn[USER_HI:USER_LO] : pendUserBits_q;
  wire drqSet = dmaEn_q && p2Wr && p2WrData[P2_DMA_REQ];
  wire drqClr = ((rdEnd || wrEnd) && viaDma_q) || opDma;

  wire [7:0] statusNow = {userBits_q, cmdFlag_q, 1'b0, inFull_q, outFull_q};

  // ----------------------------------------------------------------
  // Host access sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      HOST_IDLE: begin
        if (rdAct) begin
          state_d = HOST_READ;
        end else if (wrAct) begin
          state_d = HOST_WRITE;
        end
      end
      HOST_READ: begin
        if (!rdAct) begin
          state_d = HOST_IDLE;
        end
      end
      HOST_WRITE: begin
        if (!wrAct) begin
          state_d = HOST_IDLE;
        end
      end
      default: state_d = HOST_IDLE;
    endcase
  end

  // Sequencer register plus per-access latches
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= HOST_IDLE;
      rdStatus_q <= 1'b0;
      wrA0_q <= 1'b0;
      viaDma_q <= 1'b0;
      rdData_q <= BUF_RESET;
      wrData_q <= BUF_RESET;
    end else if (clkEn) begin
      state_q <= state_d;
      if (state_q == HOST_IDLE) begin
        rdStatus_q <= a0Eff;
        viaDma_q <= dmaSel;
        rdData_q <= a0Eff ? statusNow : outBuf_q;
      end
      if (wrAct) begin
        wrData_q <= busIn;
        wrA0_q <= a0Eff;
      end
    end
  end

  // Bus drive follows the read strobe only
  assign busOe = (state_q == HOST_READ) && rdAct;
  assign busOut = rdData_q;

  // ----------------------------------------------------------------
  // Buffers and status byte
  // ----------------------------------------------------------------
  // Two independent buffers, one per direction
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      inBuf_q <= BUF_RESET;
      outBuf_q <= BUF_RESET;
    end else if (clkEn) begin
      if (wrEnd) begin
        inBuf_q <= wrData_q;
      end
      if (cpuOutWr) begin
        outBuf_q <= cpuOutData;
      end
    end
  end

  // Hardware flags; reset clears them all
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      outFull_q <= 1'b0;
      inFull_q <= 1'b0;
      cmdFlag_q <= 1'b0;
    end else if (clkEn) begin
      outFull_q <= obfSet ? 1'b1 : (obfClr ? 1'b0 : outFull_q);
      inFull_q <= ibfSet ? 1'b1 : (ibfClr ? 1'b0 : inFull_q);
      if (wrEnd) begin
        cmdFlag_q <= wrA0_q;
      end
    end
  end

  // Internal updates held back while the host reads status
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pendObf_q <= 1'b0;
      pendIbfClr_q <= 1'b0;
      pendUser_q <= 1'b0;
      pendUserBits_q <= USER_RESET;
      userBits_q <= USER_RESET;
    end else if (clkEn) begin
      pendObf_q <= statusLock && (cpuOutWr || pendObf_q);
      pendIbfClr_q <= statusLock && (cpuInRd || pendIbfClr_q);
      pendUser_q <= statusLock && (opLoad || pendUser_q);
      if (opLoad) begin
        pendUserBits_q <= accIn[USER_HI:USER_LO];
      end
      if (userApply) begin
        userBits_q <= userSrc;
      end
    end
  end

  assign inData = inBuf_q;
  assign statusByte = statusNow;

  // ----------------------------------------------------------------
  // Port 2 and expander pins
  // ----------------------------------------------------------------
  // Pin modes latch on their enable ops and hold until reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flagsEn_q <= 1'b0;
      dmaEn_q <= 1'b0;
      dmaReq_q <= 1'b0;
      p2Latch_q <= P2_RESET;
    end else if (clkEn) begin
      flagsEn_q <= flagsEn_q || opFlags;
      dmaEn_q <= dmaEn_q || opDma;
      dmaReq_q <= drqSet ? 1'b1 : (drqClr ? 1'b0 : dmaReq_q);
      if (p2Wr) begin
        p2Latch_q <= p2WrData;
      end
    end
  end

  // Pin values; the port bit gates each flag so a zero holds it low
  wire pinObf = flagsEn_q ? (p2Latch_q[P2_OUT_FULL] && outFull_q) : p2Latch_q[P2_OUT_FULL];
  wire pinIbf = flagsEn_q ? (p2Latch_q[P2_IN_FULL] && !inFull_q) : p2Latch_q[P2_IN_FULL];
  wire pinDrq = dmaEn_q ? dmaReq_q : p2Latch_q[P2_DMA_REQ];
  // Acknowledge pin floats high as an input once DMA is enabled
  wire pinDack = dmaEn_q ? 1'b1 : p2Latch_q[P2_DMA_ACK];
  wire [3:0] pinLow = expActive ? expNibble : p2Latch_q[3:0];

  // Registered pins keep data outputs glitch free
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      p2Out_q <= P2_RESET;
      expStb_q <= 1'b1;
    end else if (clkEn) begin
      p2Out_q <= {pinDack, pinDrq, pinIbf, pinObf, pinLow};
      expStb_q <= expActive ? expStrobe : 1'b1;
    end
  end

  assign p2Out = p2Out_q;
  assign expanderStrobePin = expStb_q;

  // ----------------------------------------------------------------
  // Instruction cycle strobe
  // ----------------------------------------------------------------
  // Free-running divider; one-clock pulse on each wrap
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cyc_q <= 4'h0;
      sync_q <= 1'b0;
    end else if (clkEn) begin
      cyc_q <= (cyc_q == CYCLE_LAST) ? 4'h0 : cyc_q + 4'h1;
      sync_q <= (cyc_q == CYCLE_LAST);
    end
  end

  assign cycleStrobe = sync_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst || !clkEn);

  sequence s_wr_end;
    (state_q == HOST_WRITE) && !wrAct;
  endsequence

  sequence s_data_rd_end;
    (state_q == HOST_READ) && !rdAct && !rdStatus_q;
  endsequence

  property p_cmd_flag;
    s_wr_end |=> (cmdFlag_q == $past(wrA0_q));
  endproperty
  a_cmd_flag: assert property (p_cmd_flag) else $error("cmd flag wrong after write");

  property p_write_capture;
    s_wr_end |=> inFull_q && (inBuf_q == $past(wrData_q));
  endproperty
  a_write_capture: assert property (p_write_capture) else $error("write not captured");

  property p_read_clears_obf;
    (s_data_rd_end and (!cpuOutWr && !pendObf_q)) |=> !outFull_q;
  endproperty
  a_read_clears_obf: assert property (p_read_clears_obf) else $error("out-full not cleared");

  property p_cpu_write_sets_obf;
    (cpuOutWr && !statusLock) |=> outFull_q && (outBuf_q == $past(cpuOutData));
  endproperty
  a_cpu_write_sets_obf: assert property (p_cpu_write_sets_obf) else $error("out-full not set");

  property p_bus_drive;
    busOe |-> (state_q == HOST_READ) && !rdN && hostSel;
  endproperty
  a_bus_drive: assert property (p_bus_drive) else $error("bus driven outside read");

  property p_cs_ignored;
    (csN && !dmaEn_q && state_q == HOST_IDLE) |=> (state_q == HOST_IDLE) && !busOe;
  endproperty
  a_cs_ignored: assert property (p_cs_ignored) else $error("strobe taken while deselected");

  property p_sync_spacing;
    cycleStrobe |=> !cycleStrobe [*8];
  endproperty
  a_sync_spacing: assert property (p_sync_spacing) else $error("cycle strobe too frequent");

  property p_sync_period;
    cycleStrobe |-> ##[1:15] cycleStrobe;
  endproperty
  a_sync_period: assert property (p_sync_period) else $error("cycle strobe missing");

  property p_load_status;
    (opLoad && !statusLock) |=> (statusByte[7:4] == $past(accIn[7:4]));
  endproperty
  a_load_status: assert property (p_load_status) else $error("user status not loaded");

  property p_load_keeps_low;
    (opLoad && !wrEnd && !rdEnd && !cpuOutWr && !cpuInRd && !pendObf_q && !pendIbfClr_q)
      |=> $stable(statusByte[3:0]);
  endproperty
  a_load_keeps_low: assert property (p_load_keeps_low) else $error("load changed flag bits");

  property p_status_locked;
    (statusLock ##1 statusLock) |-> $stable(statusByte);
  endproperty
  a_status_locked: assert property (p_status_locked) else $error("status changed during read");

  property p_flag_pin_low;
    (flagsEn_q && !p2Latch_q[P2_OUT_FULL]) |=> !p2Out[P2_OUT_FULL];
  endproperty
  a_flag_pin_low: assert property (p_flag_pin_low) else $error("out-full pin not forced low");

  property p_ibf_pin;
    (flagsEn_q && p2Latch_q[P2_IN_FULL]) |=> (p2Out[P2_IN_FULL] == !$past(inFull_q));
  endproperty
  a_ibf_pin: assert property (p_ibf_pin) else $error("in-full pin not inverted flag");

endmodule : shbp_port

// file: tb/shbp_host_model.sv
// Purpose: Behavioural master CPU on the slave host data bus.
// Assumes: Signals change on falling clock edges; single byte transfers.
// Notes:   A released data bus shows the inverse of its last byte.
`timescale 1ns/1ps

module shbp_host_model (
  input wire logic clock,
  output logic csN,
  output logic rdN,
  output logic wrN,
  output logic cmdDataSelect,
  output logic [7:0] busIn,
  input wire logic [7:0] busOut,
  input wire logic busOe,
  output logic [7:0] rdData,
  output logic rdOk
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Idle bus from time zero
  initial begin
    {csN, rdN, wrN, cmdDataSelect} = 4'h7;
    busIn = 8'ha5;
    rdData = 8'h00;
    rdOk = 1'h0;
  end

  // Read held until an edge sees the bus driven, bounded by four edges
  task automatic readByte(input logic sel, input logic a0);
    int n;
    n = 0;
    @(negedge clock);
    csN = ~sel;
    cmdDataSelect = a0;
    rdN = 1'h0;
    do begin
      @(posedge clock);
      n++;
    end while (busOe !== 1'h1 && n < 4);
    rdOk = (busOe === 1'h1);
    rdData = busOut;
    @(negedge clock);
    {csN, rdN} = 2'h3;
    @(negedge clock);
  endtask : readByte

  // Write strobe held two edges; trailing edge then two released cycles
  task automatic writeByte(input logic sel, input logic a0, input logic [7:0] d);
    @(negedge clock);
    csN = ~sel;
    cmdDataSelect = a0;
    busIn = d;
    wrN = 1'h0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    wrN = 1'h1;
    busIn = ~d; // No pull-up: avoid a stale byte looking valid
    repeat (2) @(negedge clock);
    csN = 1'h1;
  endtask : writeByte
endmodule : shbp_host_model

// file: tb/shbp_port_tb.sv
// Purpose: Self-checking bench for the slave host buffer port.
// Assumes: Host model drives the host pins; internal ops driven here.
// Notes:   Every check is noted in a queue and drained by a watcher.
`timescale 1ns/1ps

module shbp_port_tb;
  import shbp_pkg::*;
  logic clock = 1'h0, rst = 1'h1, clkEn = 1'h1;
  logic csN, rdN, wrN, cmdDataSelect, busOe, cycleStrobe, rdOk, expanderStrobePin;
  logic [7:0] busIn, busOut, inData, statusByte, p2Out, rdData;
  logic opValid = 1'h0, cpuOutWr = 1'h0, cpuInRd = 1'h0, p2Wr = 1'h0, dmaAckN = 1'h1;
  logic expActive = 1'h0, expStrobe = 1'h1, seenStb = 1'h0;
  logic [7:0] opCode = 8'h00, accIn = 8'h00, cpuOutData = 8'h00, p2WrData = 8'hff;
  logic [7:0] rnd = 8'h55, last, seenVal, user;
  logic [3:0] expNibble = 4'h0;
  logic [7:0] expQ[$];
  int fails = 0, n_tests = 0, cyc = 0, pulses = 0;

  always #20 clock = ~clock;

  shbp_port shbp_port_i (.clock, .rst, .clkEn, .csN, .rdN, .wrN, .cmdDataSelect, .busIn, .busOut,
    .busOe, .opValid, .opCode, .accIn, .cpuOutWr, .cpuOutData, .cpuInRd, .inData, .statusByte,
    .cycleStrobe, .p2Wr, .p2WrData, .dmaAckN, .expActive, .expNibble, .expStrobe, .p2Out,
    .expanderStrobePin);
  shbp_host_model shbp_host_model_i (.clock, .csN, .rdN, .wrN, .cmdDataSelect, .busIn, .busOut,
    .busOe, .rdData, .rdOk);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick

  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'h1;
    @(negedge clock);
    s = 1'h0;
  endtask : pulse

  // Note the expectation, hand the seen value to the watcher
  task automatic chk(input logic [7:0] e, input logic [7:0] a);
    expQ.push_back(e);
    seenVal = a;
    seenStb = 1'h1;
    @(posedge clock);
    #1 seenStb = 1'h0;
    // Return on a falling edge so the next stimulus lands there too
    @(negedge clock);
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // Watcher, cycle strobe counter and hang guard
  always @(posedge clock) begin
    cyc++;
    if (cycleStrobe === 1'h1) pulses++;
    if (seenStb === 1'h1) begin
      n_tests++;
      if (seenVal !== expQ[0]) begin
        fails++;
        $display("[FAIL] %0t saw %h, expected %h", $time, seenVal, expQ[0]);
      end
      void'(expQ.pop_front());
    end
    if (cyc == 5000) begin
      fails++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    tick(10);
    rst = 1'h0;
    chk(8'h00, statusByte);
    chk(8'hff, p2Out);
    chk(8'h00, {7'h00, busOe});
    chk(8'h01, {7'h00, expanderStrobePin});
    pulses = 0;
    tick(150);
    chk(8'd10, 8'(pulses));
    $display("reset and cycle strobe done");
    // Data then command write, both land in the input buffer
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      shbp_host_model_i.writeByte(1'h1, i[0], rnd);
      tick(2);
      chk(rnd, inData);
      chk({4'h0, i[0], 3'h2}, statusByte);
    end
    pulse(cpuInRd);
    tick(2);
    chk(8'h08, statusByte);
    last = rnd;
    rnd = lfsr(rnd);
    shbp_host_model_i.writeByte(1'h0, 1'h0, rnd);
    tick(2);
    chk(last, inData);
    chk(8'h08, statusByte);
    $display("host writes done");
    // Output buffer filled inside, read by the host
    rnd = lfsr(rnd);
    cpuOutData = rnd;
    pulse(cpuOutWr);
    tick(2);
    chk(8'h09, statusByte);
    shbp_host_model_i.readByte(1'h1, 1'h0);
    chk(rnd, rdData);
    chk(8'h01, {7'h00, rdOk});
    tick(2);
    chk(8'h08, statusByte);
    chk(8'h00, {7'h00, busOe});
    // Load status keeps the hardware flags
    rnd = lfsr(rnd);
    accIn = rnd;
    user = {rnd[7:4], 4'h8};
    opCode = OP_LOAD_STATUS;
    pulse(opValid);
    tick(2);
    chk(user, statusByte);
    shbp_host_model_i.readByte(1'h1, 1'h1);
    chk(user, rdData);
    // Internal write during a status read is held off, then applied
    fork
      shbp_host_model_i.readByte(1'h1, 1'h1);
      begin
        tick(1);
        pulse(cpuOutWr);
      end
    join
    chk(user, rdData);
    tick(2);
    chk(user | 8'h01, statusByte);
    $display("status done");
    // Flag pins: plain first, then enabled
    p2WrData = 8'h00;
    pulse(p2Wr);
    tick(2);
    chk(8'h00, p2Out);
    opCode = OP_EN_FLAGS;
    pulse(opValid);
    p2WrData = 8'hff;
    pulse(p2Wr);
    shbp_host_model_i.writeByte(1'h1, 1'h0, rnd);
    tick(2);
    chk(8'hdf, p2Out);
    shbp_host_model_i.readByte(1'h1, 1'h0);
    tick(2);
    chk(8'hcf, p2Out);
    p2WrData = 8'hdf;
    pulse(p2Wr);
    pulse(cpuInRd);
    tick(2);
    chk(8'hcf, p2Out);
    // DMA request raised, then dropped by an acknowledged read
    opCode = OP_EN_DMA;
    pulse(opValid);
    p2WrData = 8'h4f;
    pulse(p2Wr);
    tick(2);
    chk(8'hcf, p2Out);
    dmaAckN = 1'h0;
    shbp_host_model_i.readByte(1'h0, 1'h0);
    dmaAckN = 1'h1;
    tick(2);
    chk(8'h8f, p2Out);
    // Expander access drives the low nibble and strobe pin
    rnd = lfsr(rnd);
    expNibble = rnd[3:0];
    expStrobe = 1'h0;
    expActive = 1'h1;
    tick(2);
    chk({4'h8, rnd[3:0]}, p2Out);
    chk(8'h00, {7'h00, expanderStrobePin});
    expActive = 1'h0;
    $display("port two done");
    // Frozen enable holds every flag; a second reset then clears them
    shbp_host_model_i.writeByte(1'h1, 1'h1, rnd);
    clkEn = 1'h0;
    pulse(cpuInRd);
    tick(2);
    chk({user[7:4], 4'ha}, statusByte);
    clkEn = 1'h1;
    rst = 1'h1;
    tick(2);
    rst = 1'h0;
    chk(8'h00, statusByte);
    chk(8'hff, p2Out);
    $display("freeze and second reset done");
    report_and_stop();
  end
endmodule : shbp_port_tb
